// *** verilog/uraf_rx_core.sv ***
// serial receive path with address frame filtering and apb registers
// assumes an apb3 master on ref_clk, a transmitter on ref_clk, an asynchronous rx pin
//
// Operation
// - filter on: drop frames without address marking
// - 5 to 8 bits: first stop is type
// - nine bits: ninth data bit is type
// - type one is address, zero data
// - transmitter ignores the filter mode bit
// - kept address frame buffered, sets complete flag
// - filter off: accept every frame, data or address
// - one character size shared with transmitter
// - 16 samples per bit, 8 double speed
// - first vote sample 8, or 4
// - middle vote sample 9, or 5
// - five to ten data plus parity bits
// - tolerate about two percent baud error
// - majority of three centre samples
// - complete flag tracks unread buffer data

`timescale 1ns/1ps
`default_nettype none

module uraf_rx_core (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [3:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  rxPin,
  input  wire logic                  txShiftDone,
  output var  uraf_pkg::uraf_tx_cfg_t txCfg
);

  // ***********************
  // declarations
  // ***********************
  logic [2:0]               rxSync;
  logic                     rxLine;
  logic                     filterMode;
  logic                     doubleSpeed;
  logic                     rxEnable;
  logic                     parityEnable;
  logic                     parityOdd;
  logic                     txDone;
  logic                     overrun;
  logic [11:0]              baudDivisor;
  logic [11:0]              baudCount;
  logic                     sampleTick;
  uraf_pkg::uraf_rx_state_t state;
  logic                     armed;
  logic [3:0]               bitIndex;
  logic [3:0]               lastData;
  logic [8:0]               shiftData;
  logic                     parityBit;
  logic                     voteDone;
  logic                     voteBit;
  logic                     startBit;
  logic                     busy;
  uraf_pkg::uraf_entry_t    fifoMem [uraf_pkg::FIFO_DEPTH];
  uraf_pkg::uraf_entry_t    headEntry;
  uraf_pkg::uraf_entry_t    newEntry;
  logic                     wrPtr;
  logic                     rdPtr;
  logic [1:0]               fillCount;
  logic [1:0]               next_fillCount;
  logic                     rxcFlag;
  logic                     isNine;
  logic                     frameDone;
  logic                     frameType;
  logic                     keepFrame;
  logic                     pushEntry;
  logic                     lostFrame;
  logic                     popEntry;
  logic                     popArmed;
  logic                     apbSetup;
  logic                     apbDone;
  logic                     apbWrite;
  logic [31:0]              readValue;

  function automatic logic reg_mapped(input logic [3:0] a);
    reg_mapped = a == uraf_pkg::ADDR_CSA || a == uraf_pkg::ADDR_DATA ||
                 a == uraf_pkg::ADDR_CSB || a == uraf_pkg::ADDR_BAUD;
  endfunction

  // ***********************
  // pin synchroniser
  // ***********************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxSync <= 3'h7;
    end else begin
      rxSync <= {rxSync[1:0], rxPin};
    end
  end

  // line changes only once the last two stages agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxLine <= 1'b1;
    end else if (rxSync[1] == rxSync[2]) begin
      rxLine <= rxSync[1];
    end
  end

  // ***********************
  // sample clock
  // ***********************
  // one tick every divisor plus one cycles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      baudCount  <= uraf_pkg::BAUD_RST;
      sampleTick <= 1'b0;
    end else if (!rxEnable || baudCount == 12'h000) begin
      baudCount  <= baudDivisor;
      sampleTick <= rxEnable;
    end else begin
      baudCount  <= baudCount - 12'h001;
      sampleTick <= 1'b0;
    end
  end

  // ***********************
  // bit recovery
  // ***********************
  always_comb begin
    busy     = state != uraf_pkg::RX_IDLE;
    startBit = !busy && sampleTick && armed && !rxLine;
    isNine   = txCfg.charSize == uraf_pkg::SIZE_NINE;
    lastData = uraf_pkg::char_bits(txCfg.charSize) - 4'h1;
  end

  uraf_bit_vote u_vote (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .sampleTick  (sampleTick),
    .startBit    (startBit),
    .run         (busy),
    .doubleSpeed (doubleSpeed),
    .lineLevel   (rxLine),
    .voteDone    (voteDone),
    .voteBit     (voteBit)
  );

  // high to low edge needs a high sample first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
    end else if (!rxEnable) begin
      armed <= 1'b0;
    end else if (startBit) begin
      armed <= 1'b0;
    end else if (!busy && sampleTick && rxLine) begin
      armed <= 1'b1;
    end else if (state == uraf_pkg::RX_STOP && voteDone) begin
      armed <= voteBit;
    end
  end

  // ***********************
  // frame state machine
  // ***********************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= uraf_pkg::RX_IDLE;
    end else if (!rxEnable) begin
      state <= uraf_pkg::RX_IDLE;
    end else begin
      unique case (state)
        uraf_pkg::RX_IDLE: begin
          if (startBit) begin
            state <= uraf_pkg::RX_START;
          end
        end
        uraf_pkg::RX_START: begin
          // high vote means a noise spike
          if (voteDone) begin
            state <= voteBit ? uraf_pkg::RX_IDLE : uraf_pkg::RX_DATA;
          end
        end
        uraf_pkg::RX_DATA: begin
          if (voteDone && bitIndex == lastData) begin
            state <= parityEnable ? uraf_pkg::RX_PARITY : uraf_pkg::RX_STOP;
          end
        end
        uraf_pkg::RX_PARITY: begin
          if (voteDone) begin
            state <= uraf_pkg::RX_STOP;
          end
        end
        uraf_pkg::RX_STOP: begin
          // only the first stop bit is looked at
          if (voteDone) begin
            state <= uraf_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // data bits arrive lsb first, unused upper bits stay zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bitIndex  <= 4'h0;
      shiftData <= 9'h000;
      parityBit <= 1'b0;
    end else if (voteDone) begin
      if (state == uraf_pkg::RX_START) begin
        bitIndex  <= 4'h0;
        shiftData <= 9'h000;
      end else if (state == uraf_pkg::RX_DATA) begin
        bitIndex            <= bitIndex + 4'h1;
        shiftData[bitIndex] <= voteBit;
      end else if (state == uraf_pkg::RX_PARITY) begin
        parityBit <= voteBit;
      end
    end
  end

  // ***********************
  // address filter
  // ***********************
  always_comb begin
    frameDone = state == uraf_pkg::RX_STOP && voteDone;
    frameType = isNine ? shiftData[8] : voteBit;
    keepFrame = !filterMode || frameType;
    popEntry  = apbDone && popArmed && fillCount != 2'h0;
    pushEntry = frameDone && keepFrame && (fillCount != 2'h2 || popEntry);
    lostFrame = frameDone && keepFrame && !pushEntry;
    newEntry.data      = shiftData;
    newEntry.frameErr  = !voteBit;
    newEntry.parityErr = parityEnable && (parityBit != (^shiftData ^ parityOdd));
    next_fillCount = fillCount + {1'b0, pushEntry} - {1'b0, popEntry};
    headEntry = fifoMem[rdPtr];
  end

  // ***********************
  // receive buffer
  // ***********************
  always_ff @(posedge ref_clk) begin
    if (pushEntry) begin
      fifoMem[wrPtr] <= newEntry;
    end
  end

  // disabling the receiver flushes the buffer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr     <= 1'b0;
      rdPtr     <= 1'b0;
      fillCount <= 2'h0;
    end else if (!rxEnable) begin
      wrPtr     <= 1'b0;
      rdPtr     <= 1'b0;
      fillCount <= 2'h0;
    end else begin
      wrPtr     <= wrPtr ^ pushEntry;
      rdPtr     <= rdPtr ^ popEntry;
      fillCount <= next_fillCount;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxcFlag <= 1'b0;
    end else begin
      rxcFlag <= rxEnable && next_fillCount != 2'h0;
    end
  end

  // a lost frame wins over the clearing read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      overrun <= 1'b0;
    end else if (lostFrame) begin
      overrun <= 1'b1;
    end else if (popEntry || !rxEnable) begin
      overrun <= 1'b0;
    end
  end

  // ***********************
  // software registers
  // ***********************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filterMode   <= 1'b0;
      doubleSpeed  <= 1'b0;
      rxEnable     <= 1'b0;
      parityEnable <= 1'b0;
      parityOdd    <= 1'b0;
      baudDivisor  <= uraf_pkg::BAUD_RST;
      txCfg        <= '{charSize: uraf_pkg::SIZE_RST, twoStop: 1'b0, ninthBit: 1'b0};
    end else if (apbWrite) begin
      case (paddr)
        uraf_pkg::ADDR_CSA: begin
          filterMode  <= pwdata[uraf_pkg::CSA_FILTER];
          doubleSpeed <= pwdata[uraf_pkg::CSA_DBL];
        end
        uraf_pkg::ADDR_CSB: begin
          txCfg.ninthBit <= pwdata[uraf_pkg::CSB_TXNINE];
          txCfg.charSize <= pwdata[uraf_pkg::CSB_SIZE +: 3];
          txCfg.twoStop  <= pwdata[uraf_pkg::CSB_TWOSTOP];
          rxEnable       <= pwdata[uraf_pkg::CSB_RXEN];
          parityEnable   <= pwdata[uraf_pkg::CSB_PAREN];
          parityOdd      <= pwdata[uraf_pkg::CSB_PARODD];
        end
        uraf_pkg::ADDR_BAUD: begin
          baudDivisor <= pwdata[11:0];
        end
        default: begin
        end
      endcase
    end
  end

  // transmit complete: set wins over write one to clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txDone <= 1'b0;
    end else if (txShiftDone) begin
      txDone <= 1'b1;
    end else if (apbWrite && paddr == uraf_pkg::ADDR_CSA && pwdata[uraf_pkg::CSA_TXC]) begin
      txDone <= 1'b0;
    end
  end

  // ***********************
  // apb slave
  // ***********************
  always_comb begin
    apbSetup  = psel && !penable;
    apbDone   = psel && penable && pready;
    apbWrite  = apbDone && pwrite && !pslverr;
    readValue = 32'h0000_0000;
    case (paddr)
      uraf_pkg::ADDR_CSA: begin
        readValue[uraf_pkg::CSA_FILTER] = filterMode;
        readValue[uraf_pkg::CSA_DBL]    = doubleSpeed;
        readValue[uraf_pkg::CSA_PERR]   = rxcFlag && headEntry.parityErr;
        readValue[uraf_pkg::CSA_OVR]    = overrun;
        readValue[uraf_pkg::CSA_FERR]   = rxcFlag && headEntry.frameErr;
        readValue[uraf_pkg::CSA_TXC]    = txDone;
        readValue[uraf_pkg::CSA_RXC]    = rxcFlag;
      end
      uraf_pkg::ADDR_DATA: begin
        readValue[7:0] = rxcFlag ? headEntry.data[7:0] : 8'h00;
      end
      uraf_pkg::ADDR_CSB: begin
        readValue[uraf_pkg::CSB_TXNINE]      = txCfg.ninthBit;
        readValue[uraf_pkg::CSB_RXNINE]      = rxcFlag && headEntry.data[8];
        readValue[uraf_pkg::CSB_SIZE +: 3]   = txCfg.charSize;
        readValue[uraf_pkg::CSB_RXEN]        = rxEnable;
        readValue[uraf_pkg::CSB_PAREN]       = parityEnable;
        readValue[uraf_pkg::CSB_PARODD]      = parityOdd;
        readValue[uraf_pkg::CSB_TWOSTOP]     = txCfg.twoStop;
      end
      uraf_pkg::ADDR_BAUD: begin
        readValue[11:0] = baudDivisor;
      end
      default: begin
      end
    endcase
  end

  // answer in the first access cycle, data sampled at setup
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      popArmed <= 1'b0;
    end else begin
      // pop only an entry that the setup cycle returned
      popArmed <= apbSetup && !pwrite && paddr == uraf_pkg::ADDR_DATA && rxcFlag;
      pready  <= apbSetup;
      pslverr <= apbSetup && !reg_mapped(paddr);
      prdata  <= (apbSetup && !pwrite) ? readValue : 32'h0000_0000;
    end
  end

  // ***********************
  // checks
  // ***********************
  default clocking ccb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence dropEv;
    frameDone && filterMode && !frameType && !popEntry;
  endsequence

  sequence keepEv;
    frameDone && keepFrame && !popEntry && fillCount != 2'h2;
  endsequence

  drop_no_store_a: assert property (dropEv |=> $stable(fillCount) && $stable(overrun) && $stable(wrPtr))
    else $error("filtered data frame reached the buffer");
  drop_flags_a: assert property (dropEv ##0 fillCount == 2'h0 |=> !rxcFlag ##1 !rxcFlag || fillCount != 2'h0)
    else $error("filtered frame touched the complete flag");
  keep_buffered_a: assert property (keepEv |=> fillCount == $past(fillCount) + 2'h1 && rxcFlag)
    else $error("accepted frame not buffered");
  nine_type_a: assert property (frameDone && filterMode && isNine && !shiftData[8] |-> !pushEntry)
    else $error("ninth bit zero frame kept under filter");
  stop_type_a: assert property (frameDone && filterMode && !isNine && voteBit && fillCount == 2'h0 |=> rxcFlag)
    else $error("stop bit one frame not taken as address");
  open_accept_a: assert property (frameDone && !filterMode && fillCount == 2'h0 |=> rxcFlag)
    else $error("frame dropped with filter off");
  rxc_track_a: assert property (rxcFlag == (fillCount != 2'h0))
    else $error("complete flag disagrees with buffer fill");
  tx_unaffected_a: assert property ($changed(filterMode) |-> $stable(txCfg))
    else $error("filter mode change moved the transmitter setup");
  size_shared_a: assert property (state == uraf_pkg::RX_DATA && voteDone && bitIndex == lastData |=> state != uraf_pkg::RX_DATA)
    else $error("data bit count does not follow shared size");

endmodule

`default_nettype wire

// *** verilog/uraf_pkg.sv ***
// constants, field layout and types for the receive path with address filtering
// assumes the user compiles it before every design file of this block

package uraf_pkg;

  // ***********************
  // register byte offsets
  // ***********************
  localparam logic [3:0] ADDR_CSA  = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_CSB  = 4'h8;
  localparam logic [3:0] ADDR_BAUD = 4'hc;

  // ***********************
  // ctrl_status_a fields
  // ***********************
  localparam int CSA_FILTER = 0;
  localparam int CSA_DBL    = 1;
  localparam int CSA_PERR   = 2;
  localparam int CSA_OVR    = 3;
  localparam int CSA_FERR   = 4;
  localparam int CSA_TXC    = 6;
  localparam int CSA_RXC    = 7;

  // ***********************
  // ctrl_status_b fields
  // ***********************
  localparam int CSB_TXNINE  = 0;
  localparam int CSB_RXNINE  = 1;
  localparam int CSB_SIZE    = 2;
  localparam int CSB_RXEN    = 5;
  localparam int CSB_PAREN   = 6;
  localparam int CSB_PARODD  = 7;
  localparam int CSB_TWOSTOP = 8;

  // ***********************
  // reset values and codes
  // ***********************
  localparam logic [11:0] BAUD_RST  = 12'h000;
  localparam logic [2:0]  SIZE_RST  = 3'h0;
  localparam logic [2:0]  SIZE_NINE = 3'h7;
  localparam int          FIFO_DEPTH = 2;

  // ***********************
  // sampling counts
  // ***********************
  localparam logic [4:0] SPB_NORM   = 5'h10;
  localparam logic [4:0] SPB_DBL    = 5'h08;
  localparam logic [4:0] VOTE1_NORM = 5'h08;
  localparam logic [4:0] VOTE1_DBL  = 5'h04;
  localparam logic [4:0] VOTEM_NORM = 5'h09;
  localparam logic [4:0] VOTEM_DBL  = 5'h05;

  typedef struct packed {
    logic [8:0] data;
    logic       frameErr;
    logic       parityErr;
  } uraf_entry_t;

  typedef struct packed {
    logic [2:0] charSize;
    logic       twoStop;
    logic       ninthBit;
  } uraf_tx_cfg_t;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uraf_rx_state_t;

  // two or three high samples give one
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  // data bits per character; reserved codes act as eight
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

endpackage

// *** verilog/uraf_bit_vote.sv ***
// sample counter and three sample majority vote for one serial bit
// assumes a one cycle sample tick and a filtered line, both on ref_clk

`timescale 1ns/1ps
`default_nettype none

module uraf_bit_vote (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic sampleTick,
  input  wire logic startBit,
  input  wire logic run,
  input  wire logic doubleSpeed,
  input  wire logic lineLevel,
  output logic      voteDone,
  output logic      voteBit
);

  logic [4:0] sampleNum;
  logic [4:0] nextNum;
  logic [4:0] spb;
  logic [4:0] first;
  logic [4:0] mid;
  logic [4:0] last;
  logic [2:0] window;
  logic       inWindow;

  always_comb begin
    spb   = doubleSpeed ? uraf_pkg::SPB_DBL : uraf_pkg::SPB_NORM;
    first = doubleSpeed ? uraf_pkg::VOTE1_DBL : uraf_pkg::VOTE1_NORM;
    mid   = doubleSpeed ? uraf_pkg::VOTEM_DBL : uraf_pkg::VOTEM_NORM;
    last  = mid + 5'h01;
    if (startBit || sampleNum == spb) begin
      nextNum = 5'h01;
    end else begin
      nextNum = sampleNum + 5'h01;
    end
    inWindow = sampleTick && run && nextNum >= first && nextNum <= last;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sampleNum <= 5'h00;
    end else if (sampleTick && (run || startBit)) begin
      sampleNum <= nextNum;
    end else if (!run) begin
      sampleNum <= 5'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      window   <= 3'h7;
      voteDone <= 1'b0;
      voteBit  <= 1'b1;
    end else begin
      voteDone <= inWindow && nextNum == last;
      if (inWindow) begin
        window <= {window[1:0], lineLevel};
      end
      if (inWindow && nextNum == last) begin
        voteBit <= uraf_pkg::maj3({window[1:0], lineLevel});
      end
    end
  end

  default clocking vcb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  vote_point_a: assert property (voteDone |-> sampleNum == mid + 5'h01)
    else $error("vote taken off the centre samples");
  count_wrap_a: assert property (sampleTick && run && !startBit && sampleNum == spb |=> sampleNum == 5'h01)
    else $error("sample count did not wrap at samples per bit");
  mid_sample_a: assert property (sampleTick && run && nextNum == mid |=> window[0] == $past(lineLevel))
    else $error("middle sample not captured");
  majority_a: assert property (voteDone |-> voteBit == uraf_pkg::maj3(window))
    else $error("vote is not the majority of the window");

endmodule

`default_nettype wire

// *** verif/uraf_serial_master.sv ***
// serial transmitter model driving the receive pin of the block
// assumes go is a one cycle pulse given while busy is low

`timescale 1ns/1ps
`default_nettype none

module uraf_serial_master #(
  parameter int NBITS = 9
) (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [9:0] payload,
  input  wire logic [4:0] bitClocks,
  output logic            rxPin,
  output logic            busy
);
  int i;

  initial begin
    rxPin = 1'b1;
    busy  = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        // start, payload lsb first with type bit last, closing stop
        for (i = 0; i <= NBITS + 1; i++) begin
          rxPin <= (i == 0) ? 1'b0 : (i > NBITS) ? 1'b1 : payload[i - 1];
          repeat (bitClocks) @(posedge ref_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// *** verif/tb_uraf_rx_address_filter.sv ***
// self-checking bench for the receive path with address filtering
// assumes the package is compiled first and the serial master model

`timescale 1ns/1ps
`default_nettype none

module tb_uraf_rx_address_filter;
  logic                   ref_clk     = 1'b0;
  logic                   nrst        = 1'b0;
  logic                   psel        = 1'b0;
  logic                   penable     = 1'b0;
  logic                   pwrite      = 1'b0;
  logic [3:0]             paddr       = 4'h0;
  logic [31:0]            pwdata      = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   rxPin;
  logic                   txShiftDone = 1'b0;
  uraf_pkg::uraf_tx_cfg_t txCfg;
  logic                   go          = 1'b0;
  logic [9:0]             payload     = 10'h0;
  logic [4:0]             bitClocks   = 5'h10;
  logic                   busy;
  logic [31:0]            rd;
  logic                   er;
  int                     nMismatch   = 0;
  int                     totalChecks = 0;

  always #2 ref_clk = ~ref_clk;

  uraf_rx_core dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxPin(rxPin), .txShiftDone(txShiftDone), .txCfg(txCfg)
  );

  uraf_serial_master far_u (
    .ref_clk(ref_clk), .go(go), .payload(payload), .bitClocks(bitClocks),
    .rxPin(rxPin), .busy(busy)
  );

  // **********************
  // access tasks
  // **********************
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [9:0] p, input logic [4:0] c);
    payload <= p; bitClocks <= c; go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    do begin
      @(posedge ref_clk);
    end while (busy !== 1'b0);
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic txPulse();
    txShiftDone <= 1'b1;
    @(posedge ref_clk);
    txShiftDone <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // **********************
  // tests
  // **********************
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("status a", 32'h0, rd);
    apb(1'b0, uraf_pkg::ADDR_CSB, 32'h0); chk("status b", 32'h0, rd);
    apb(1'b0, 4'h2, 32'h0); chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, uraf_pkg::ADDR_BAUD, 32'h0);
    apb(1'b1, uraf_pkg::ADDR_CSB, 32'h3c);
    chk("tx size", 32'h7, {29'h0, txCfg.charSize});
    apb(1'b1, uraf_pkg::ADDR_CSA, 32'h1);
    frame(10'h0a5, 5'h10);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("dropped data", 32'h1, rd);
    frame(10'h1a5, 5'h10);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("address kept", 32'h81, rd);
    apb(1'b0, uraf_pkg::ADDR_CSB, 32'h0); chk("ninth bit", 32'h3e, rd);
    apb(1'b0, uraf_pkg::ADDR_DATA, 32'h0); chk("address data", 32'ha5, rd);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("buffer empty", 32'h1, rd);
    apb(1'b1, uraf_pkg::ADDR_CSA, 32'h0);
    frame(10'h03c, 5'h10);
    apb(1'b0, uraf_pkg::ADDR_CSB, 32'h0); chk("data ninth", 32'h3c, rd);
    apb(1'b0, uraf_pkg::ADDR_DATA, 32'h0); chk("data kept", 32'h3c, rd);
    txPulse();
    apb(1'b1, uraf_pkg::ADDR_CSA, 32'h41);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("tx clear", 32'h1, rd);
    txPulse();
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("tx filter on", 32'h41, rd);
    apb(1'b1, uraf_pkg::ADDR_CSB, 32'h2c);
    apb(1'b1, uraf_pkg::ADDR_CSA, 32'h3);
    frame(10'h05a, 5'h08);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("stop type drop", 32'h43, rd);
    frame(10'h15a, 5'h08);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("stop type kept", 32'hc3, rd);
    apb(1'b0, uraf_pkg::ADDR_DATA, 32'h0); chk("short data", 32'h5a, rd);
    apb(1'b1, uraf_pkg::ADDR_CSA, 32'h2);
    frame(10'h05a, 5'h08);
    frame(10'h1a5, 5'h08);
    frame(10'h13c, 5'h08);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("error and overrun", 32'hda, rd);
    apb(1'b0, uraf_pkg::ADDR_DATA, 32'h0); chk("error frame data", 32'h5a, rd);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("overrun cleared", 32'hc2, rd);
    apb(1'b0, uraf_pkg::ADDR_DATA, 32'h0); chk("second frame data", 32'ha5, rd);
    apb(1'b1, uraf_pkg::ADDR_CSB, 32'h12d);
    chk("tx setup", 32'hf, {27'h0, txCfg});
    apb(1'b1, uraf_pkg::ADDR_CSB, 32'h6c);
    frame(10'h15a, 5'h08);
    apb(1'b0, uraf_pkg::ADDR_CSA, 32'h0); chk("parity error", 32'hc6, rd);
    apb(1'b0, uraf_pkg::ADDR_DATA, 32'h0); chk("parity data", 32'h5a, rd);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    complete_run();
  end
endmodule

`default_nettype wire
